// >>> pkg/snf_cfg.svh
`ifndef SNF_CFG_SVH
`define SNF_CFG_SVH
`define SNF_WORD_W 16
`define SNF_NOP_HEAD 13'h1220
`define SNF_OP_NOP 3'h1
`define SNF_OP_DIAG1 3'h2
`define SNF_OP_SWITCH 3'h3
`define SNF_ALL_ONES 16'hFFFF
`define SNF_BIT_CNT_LAST 4'hF
`define SNF_RESET_ANSWER 16'h0000
`define SNF_OP_W 3
`define SNF_SEL_BIT 3
`define SNF_ON_BIT 4
`define SNF_BYTE_W 8
`define SNF_ZERO_BYTE 8'h00
`define SNF_DIAG_ZERO 12'h000
`define SNF_SWITCH_ZERO 11'h000
`define SNF_CNT_ZERO 4'h0
`define SNF_CNT_STEP 4'h1
`define SNF_SYNC_IDLE 2'h3
`define SNF_NO_FLAGS 6'h00
`endif

// >>> pkg/snf_pkg.sv
package snf_pkg;
  // Per-channel fault detector inputs, one bit per condition.
  typedef struct packed {
    logic out_gnd;
    logic out_bat;
    logic ret_gnd;
    logic ret_bat;
    logic out_ret;
    logic open_line;
  } snf_fault_t;

  typedef enum logic [1:0] {
    SNF_IDLE = 2'b00,
    SNF_SHIFT = 2'b01,
    SNF_DONE = 2'b10
  } snf_state_t;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] csn_sync;
    logic [1:0] mosi_sync;
    logic sclk_prev;
    snf_state_t state;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [15:0] answer;
    logic [3:0] bit_cnt;
    logic [1:0] chan_on;
    logic [1:0][5:0] latched;
    snf_fault_t [1:0] fault_meta;
    snf_fault_t [1:0] fault_live;
    logic ot_meta;
    logic overtemp;
    logic miso;
  } snf_state_all_t;
endpackage : snf_pkg

// >>> hdl/snf_core.sv
`include "snf_cfg.svh"

module snf_core (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_csn_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  input snf_pkg::snf_fault_t ch0_fault_in,
  input snf_pkg::snf_fault_t ch1_fault_in,
  input wire logic overtemp_in,
  output logic [1:0] chan_on_out,
  output logic overtemp_flag_out
);
  import snf_pkg::*;

  // The whole state of the block lives in one packed struct.
  // The register holds r; next_r is the value it takes at the coming edge.
  snf_state_all_t r;
  snf_state_all_t next_r;

  // Raw detector levels, gathered per channel before synchronising.
  snf_fault_t [1:0] fault_pin;

  // Edge strobes of the link clock, found after its synchroniser.
  logic sclk_rise;
  logic sclk_fall;

  // Decoded view of the word that the last frame delivered.
  logic [`SNF_WORD_W-1:0] cmd;
  logic [`SNF_OP_W-1:0] op;
  logic sel;
  logic on_req;

  // Frame check and command classes; at most one class is true for any word.
  logic frame_ok;
  logic is_nop;
  logic is_diag;
  logic is_switch;

  // Diagnosis view of the selected channel.
  snf_fault_t sel_flags;
  logic [`SNF_BYTE_W-1:0] diag_byte;

  // The detectors are analog comparators that know nothing of our clock.
  // Their levels therefore pass two flip-flops before any decision reads them,
  // at the price of two extra cycles before a faulty channel is shut down.
  assign fault_pin[0] = ch0_fault_in;
  assign fault_pin[1] = ch1_fault_in;

  // Edges are found only from the second synchroniser stage.
  // Reading the first stage here would let a metastable level leak into the shifters.
  assign sclk_rise = r.sclk_sync[1] && !r.sclk_prev;
  assign sclk_fall = !r.sclk_sync[1] && r.sclk_prev;

  // Fields of the received word.
  assign cmd = r.rx_shift;
  assign op = cmd[`SNF_OP_W-1:0];
  assign sel = cmd[`SNF_SEL_BIT];
  assign on_req = cmd[`SNF_ON_BIT];

  // A frame counts only when a whole number of sixteen bits was clocked in.
  // The counter wraps, so a frame of thirty-two bits is still taken as whole.
  assign frame_ok = (r.bit_cnt == `SNF_CNT_ZERO);

  // The no-operation word is one fixed pattern in all sixteen bits.
  assign is_nop = (cmd[`SNF_WORD_W-1:`SNF_OP_W] == `SNF_NOP_HEAD) &&
                  (op == `SNF_OP_NOP);

  // The diagnosis request carries only the channel select besides its opcode.
  assign is_diag = (cmd[`SNF_WORD_W-1:`SNF_ON_BIT] == `SNF_DIAG_ZERO) &&
                   (op == `SNF_OP_DIAG1);

  // The channel switch carries the on request and the channel select.
  assign is_switch = (cmd[`SNF_WORD_W-1:`SNF_ON_BIT+1] == `SNF_SWITCH_ZERO) &&
                     (op == `SNF_OP_SWITCH);

  // Diagnosis byte of the selected channel.
  // The return-to-battery, output-to-return and open-line faults share one bit, so every latched flag stays visible.
  assign sel_flags = r.latched[sel];
  assign diag_byte = {1'b0,
                      1'b0,
                      !r.chan_on[sel],
                      r.overtemp,
                      sel_flags.out_gnd,
                      sel_flags.out_bat,
                      sel_flags.ret_gnd,
                      sel_flags.ret_bat | sel_flags.out_ret | sel_flags.open_line};

  // Frame handling, command decoding and fault latching.
  always_comb begin
    next_r = r;

    // Two-stage synchronisers for the link pins.
    next_r.sclk_sync = {r.sclk_sync[0], spi_sclk_in};
    next_r.csn_sync = {r.csn_sync[0], spi_csn_in};
    next_r.mosi_sync = {r.mosi_sync[0], spi_mosi_in};
    next_r.sclk_prev = r.sclk_sync[1];

    // Two-stage synchronisers for the detector levels.
    next_r.fault_meta = fault_pin;
    next_r.fault_live = r.fault_meta;
    next_r.ot_meta = overtemp_in;

    // The heat status is never frozen; it follows the sensor at all times.
    next_r.overtemp = r.ot_meta;

    // Latch faults only while the channel runs; a faulted channel turns off.
    // An off channel keeps its flags until a switch-on command for it clears them.
    for (int c = 0; c < 2; c++) begin
      if (r.chan_on[c]) begin
        next_r.latched[c] = r.latched[c] | r.fault_live[c];
        if (|r.fault_live[c]) begin
          next_r.chan_on[c] = 1'b0;
        end
      end
    end

    // Heat is a fault of the whole chip and takes both channels down.
    if (r.overtemp) begin
      next_r.chan_on = 2'b00;
    end

    case (r.state)
      // Between frames the first answer bit already stands on the data line.
      SNF_IDLE: begin
        next_r.miso = r.answer[`SNF_WORD_W-1];
        if (!r.csn_sync[1]) begin
          next_r.tx_shift = r.answer;
          next_r.bit_cnt = `SNF_CNT_ZERO;
          next_r.state = SNF_SHIFT;
        end
      end

      // Receive on the rising link edge, send on the falling one.
      SNF_SHIFT: begin
        if (sclk_rise) begin
          next_r.rx_shift = {r.rx_shift[`SNF_WORD_W-2:0], r.mosi_sync[1]};
          next_r.bit_cnt = r.bit_cnt + `SNF_CNT_STEP;
        end
        if (sclk_fall) begin
          next_r.tx_shift = {r.tx_shift[`SNF_WORD_W-2:0], 1'b0};
          next_r.miso = r.tx_shift[`SNF_WORD_W-2];
        end
        if (r.csn_sync[1]) begin
          next_r.state = SNF_DONE;
        end
      end

      // The word is decoded once, in the cycle after deselect is seen.
      // The answer stands until the next decode and leaves in the next frame.
      SNF_DONE: begin
        next_r.state = SNF_IDLE;
        if (!frame_ok) begin
          // Short frames are treated as invalid commands.
          next_r.answer = `SNF_ALL_ONES;
        end else if (is_nop) begin
          next_r.answer = cmd;
        end else if (is_diag) begin
          next_r.answer = {diag_byte, cmd[`SNF_BYTE_W-1:0]};
        end else if (is_switch) begin
          if (on_req) begin
            // While the channel runs, a fault seen in the same cycle as the clear wins over the clear.
            if (r.chan_on[sel]) begin
              next_r.latched[sel] = r.fault_live[sel];
            end else begin
              next_r.latched[sel] = `SNF_NO_FLAGS;
            end
            // A hot chip refuses to switch on; the value matches the heat flag.
            next_r.chan_on[sel] = !next_r.overtemp;
          end else begin
            next_r.chan_on[sel] = 1'b0;
          end
          next_r.answer = {`SNF_ZERO_BYTE, cmd[`SNF_BYTE_W-1:0]};
        end else begin
          next_r.answer = `SNF_ALL_ONES;
        end
      end

      default: begin
        next_r.state = SNF_IDLE;
      end
    endcase
  end

  // State register; bit count wraps to zero after exactly sixteen bits.
  // The select synchroniser resets to the idle level, so no false frame follows reset.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.csn_sync <= `SNF_SYNC_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Every output comes straight from a flip-flop.
  assign spi_miso_out = r.miso;
  assign chan_on_out = r.chan_on;
  assign overtemp_flag_out = r.overtemp;
endmodule : snf_core

// >>> sim/snf_host.sv
// Host side master; idle data is inverted so a stale bit never looks valid.
module snf_host (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic csn_out,
  output logic mosi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b0;
  end
  // One whole frame, MSB first; the answer returned belongs to the frame before.
  task automatic xfer(input logic [15:0] c, output logic [15:0] a);
    @(negedge clk_in) csn_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = c[i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      a[i] = miso_in;
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    csn_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (12) @(negedge clk_in);
  endtask : xfer
endmodule : snf_host

// >>> sim/snf_core_chk.sv
module snf_core_chk (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic spi_csn_in,
  input snf_pkg::snf_fault_t ch0_fault_in,
  input snf_pkg::snf_fault_t ch1_fault_in,
  input wire logic overtemp_in,
  input wire logic [1:0] chan_on_out,
  input wire logic overtemp_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // A heat fault lasting two cycles must shut both channels within four cycles.
  sequence ot_seen;
    overtemp_in ##1 overtemp_in;
  endsequence
  ch0_trip_a: assert property ((|ch0_fault_in) && chan_on_out[0] |-> ##[1:4] !chan_on_out[0])
    else $error("channel 0 stayed on with a fault");
  ch1_trip_a: assert property ((|ch1_fault_in) && chan_on_out[1] |-> ##[1:4] !chan_on_out[1])
    else $error("channel 1 stayed on with a fault");
  ot_both_off_a: assert property (ot_seen |-> ##[0:4] chan_on_out == 2'b00)
    else $error("heat fault left a channel on");
  ot_rise_a: assert property (overtemp_in |-> ##[1:4] overtemp_flag_out)
    else $error("heat flag did not follow");
  ot_fall_a: assert property (!overtemp_in |-> ##[1:4] !overtemp_flag_out)
    else $error("heat flag did not clear");
  ch0_on_cmd_a: assert property ($rose(chan_on_out[0]) |-> spi_csn_in)
    else $error("channel 0 on outside a decode");
  ch1_on_cmd_a: assert property ($rose(chan_on_out[1]) |-> spi_csn_in)
    else $error("channel 1 on outside a decode");
  on_cool_a: assert property ($rose(|chan_on_out) |-> !overtemp_flag_out)
    else $error("channel enabled while hot");
endmodule : snf_core_chk
bind snf_core snf_core_chk chk_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .spi_csn_in(spi_csn_in), .ch0_fault_in(ch0_fault_in), .ch1_fault_in(ch1_fault_in),
  .overtemp_in(overtemp_in), .chan_on_out(chan_on_out), .overtemp_flag_out(overtemp_flag_out));

// >>> sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import snf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ot = 1'b0, sclk, csn, mosi, miso, otf;
  logic [1:0] on;
  logic [15:0] a;
  snf_fault_t f0 = '0, f1 = '0;
  int n_errors = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  snf_host host (.clk_in(clk), .miso_in(miso), .sclk_out(sclk), .csn_out(csn), .mosi_out(mosi));
  snf_core DUT (.core_clk_in(clk), .rst_in(rst), .spi_sclk_in(sclk), .spi_csn_in(csn),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .ch0_fault_in(f0), .ch1_fault_in(f1),
    .overtemp_in(ot), .chan_on_out(on), .overtemp_flag_out(otf));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmd(input logic [15:0] c);
    host.xfer(c, a);
  endtask : cmd
  task automatic t_nop;
    cmd(16'h9101);
    cmd(16'h9101);
    chk(a, 16'h9101);
    cmd(16'h1234);
    cmd(16'h9101);
    chk(a, 16'hFFFF);
  endtask : t_nop
  // A short ground fault must trip channel 0 and stay latched until switched on again.
  task automatic t_fault;
    cmd(16'h0013);
    chk(on, 2'b01);
    f0.out_gnd = 1'b1;
    repeat (8) @(negedge clk);
    f0 = '0;
    chk(on, 2'b00);
    cmd(16'h0002);
    cmd(16'h9101);
    chk({a[13], a[11], a[7:0]}, 16'h0302);
    cmd(16'h0013);
    cmd(16'h0002);
    cmd(16'h9101);
    chk(a[13:8], 16'h0000);
  endtask : t_fault
  task automatic t_ot;
    cmd(16'h001B);
    f1.ret_bat = 1'b1;
    repeat (8) @(negedge clk);
    f1 = '0;
    chk(on, 2'b01);
    cmd(16'h000A);
    cmd(16'h9101);
    chk(a, 16'h210A);
    ot = 1'b1;
    repeat (8) @(negedge clk);
    chk({otf, on}, 16'h0004);
    ot = 1'b0;
    repeat (8) @(negedge clk);
    chk(otf, 16'h0000);
  endtask : t_ot
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_nop();
    t_fault();
    t_ot();
    tally_and_finish();
  end
  // Guard against a hung run.
  initial begin
    #1ms;
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_top
